// File: verilog/sepol_top.sv
// How it works
// RULE1 - Enable asserted powers the motor; enable removed cuts power and refuses operation.
// RULE2 - Enable source field: 0 takes the terminal, 7 always on; applies at restart.
// RULE3 - A new enable is only taken while the motor is stopped.
// RULE4 - Enable needs main power, no safety block and no alarm.
// RULE5 - With enable always on, power comes up with main power.
// RULE6 - Once the alarm clears, power returns if enable is still in effect.
// RULE7 - Allocation 0: enable assertion starts polarity detection.
// RULE8 - Allocation 0: ready rises after detection, enable stays in effect.
// RULE9 - Allocation 1: motor powered while the polarity request is asserted.
// RULE10 - Detection runs once, on the first request after power-up.
// RULE11 - Allocation 1: detection end removes power and raises ready.
// RULE12 - After detection, further request toggling is ignored.
// RULE13 - Control power restore forgets detection, so it must run again.
// RULE14 - Request set always on starts detection when main power comes.
// RULE15 - Detection is required for incremental scale without hall sensors.
// RULE16 - Host sequencing on ready first should use the separate request input.
// RULE17 - Host asserts enable before any reference, never starts motion by references.
// RULE18 - Ready stays low during an alarm or an active safety block.
`include "sepol_defines.svh"

module sepol_top #(
    parameter int DET_CYCLES = `SEPOL_DET_CYCLES
) (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [`SEPOL_ADDR_W-1:0] awaddr, // Write address.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [31:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Write byte strobes.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    output logic [1:0] bresp, // Write response.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    input wire logic [`SEPOL_ADDR_W-1:0] araddr, // Read address.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    output logic [31:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    input wire logic servo_enable_in, // Enable terminal, asynchronous.
    input wire logic polarity_detect_req, // Detection request terminal, asynchronous.
    input wire logic main_power_ok, // Main circuit power present.
    input wire logic hardwired_safety_block, // Safety block in effect.
    input wire logic alarm_active, // Servo alarm present.
    input wire logic motor_moving, // Motor not at standstill.
    output logic motor_power, // Motor energised.
    output logic servo_ready, // Drive ready for operation.
    output logic detecting // Polarity detection running.
);

    // ------------------------------------------------------------
    // Constants and state
    // ------------------------------------------------------------
    localparam logic [`SEPOL_CNT_W-1:0] DET_LAST = `SEPOL_CNT_W'(DET_CYCLES - 1);

    sepol_pkg::sepol_st_s q_ff;
    sepol_pkg::sepol_st_s nxt_q;
    logic restart;
    logic ok;
    logic en_eff;
    logic det_req;
    logic need;

    // Handshake outputs are decoded from the held flags.
    assign awready = !q_ff.aw_got && !q_ff.bvalid;
    assign wready = !q_ff.w_got && !q_ff.bvalid;
    assign arready = !q_ff.rvalid;

    // Data and status outputs come straight from flip-flops.
    assign bvalid = q_ff.bvalid;
    assign bresp = q_ff.bresp;
    assign rvalid = q_ff.rvalid;
    assign rresp = q_ff.rresp;
    assign rdata = q_ff.rdata;
    assign motor_power = q_ff.pwr;
    assign servo_ready = q_ff.rdy;
    assign detecting = q_ff.det;

    // ------------------------------------------------------------
    // Qualifiers seen by the sequencer
    // ------------------------------------------------------------

    // Only the second synchroniser stage is read here.
    always_comb begin
        ok = main_power_ok && !hardwired_safety_block && !alarm_active; // RULE4
        en_eff = (q_ff.act.src == `SEPOL_SRC_ALWAYS) || q_ff.s2[1]; // RULE2
        if (q_ff.act.alloc) begin
            det_req = q_ff.act.pol_always || q_ff.s2[0]; // RULE9 RULE14
        end else begin
            det_req = en_eff; // RULE7
        end
        need = q_ff.act.need_det && !q_ff.done; // RULE15
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // One process covers the bus slave and the sequencer, so the restart
    // command and the sequencer can never fight over the same fields.
    always_comb begin
        nxt_q = q_ff;
        restart = 1'b0;
        nxt_q.s1 = {servo_enable_in, polarity_detect_req};
        nxt_q.s2 = q_ff.s1;

        // Address and data are taken in either order and held.
        if (awvalid && awready) begin
            nxt_q.aw_got = 1'b1;
            nxt_q.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_q.w_got = 1'b1;
            nxt_q.wdata = wdata;
            nxt_q.wstrb0 = wstrb[0];
        end

        // The write lands once both halves are held; only lane 0 matters.
        if (q_ff.aw_got && q_ff.w_got) begin
            nxt_q.aw_got = 1'b0;
            nxt_q.w_got = 1'b0;
            nxt_q.bvalid = 1'b1;
            nxt_q.bresp = `SEPOL_RESP_OKAY;
            if (q_ff.awaddr == `SEPOL_CFG_OFS) begin
                if (q_ff.wstrb0) begin
                    nxt_q.cfg = sepol_pkg::sepol_cfg_s'(q_ff.wdata[`SEPOL_CFG_W-1:0]);
                end
            end else if (q_ff.awaddr == `SEPOL_CTRL_OFS) begin
                restart = q_ff.wstrb0 && q_ff.wdata[`SEPOL_CTRL_RESTART_BIT];
            end else if (q_ff.awaddr != `SEPOL_STAT_OFS) begin
                nxt_q.bresp = `SEPOL_RESP_SLVERR;
            end
        end
        if (q_ff.bvalid && bready) begin
            nxt_q.bvalid = 1'b0;
        end

        // Reads answer one cycle after the address is taken.
        if (arvalid && arready) begin
            nxt_q.rvalid = 1'b1;
            nxt_q.rresp = `SEPOL_RESP_OKAY;
            if (araddr == `SEPOL_CFG_OFS) begin
                nxt_q.rdata = {`SEPOL_CFG_PAD, q_ff.cfg};
            end else if (araddr == `SEPOL_CTRL_OFS) begin
                nxt_q.rdata = 32'h0;
            end else if (araddr == `SEPOL_STAT_OFS) begin
                nxt_q.rdata = {`SEPOL_STAT_PAD, en_eff, q_ff.done, q_ff.det,
                               q_ff.rdy, q_ff.pwr};
            end else begin
                nxt_q.rdata = 32'h0;
                nxt_q.rresp = `SEPOL_RESP_SLVERR;
            end
        end else if (q_ff.rvalid && rready) begin
            nxt_q.rvalid = 1'b0;
        end

        // Sequencer.
        case (q_ff.state)
            sepol_pkg::SEPOL_OFF: begin
                // Enable is only taken at standstill; this also brings
                // power back once an alarm clears.
                if (ok && !motor_moving) begin // RULE3 RULE4 RULE6
                    if (need) begin
                        if (det_req) begin // RULE7 RULE10 RULE14
                            nxt_q.state = sepol_pkg::SEPOL_DETECT;
                            nxt_q.cnt = '0;
                        end
                    end else if (en_eff) begin // RULE1 RULE5
                        nxt_q.state = sepol_pkg::SEPOL_ON;
                    end
                end
            end
            sepol_pkg::SEPOL_DETECT: begin
                // A dropped enable aborts in allocation 0; in allocation 1
                // the run finishes once started.
                if (!ok || (!q_ff.act.alloc && !en_eff)) begin // RULE1 RULE4
                    nxt_q.state = sepol_pkg::SEPOL_OFF;
                end else if (q_ff.cnt == DET_LAST) begin
                    nxt_q.done = 1'b1; // RULE10 RULE12
                    if (q_ff.act.alloc) begin
                        nxt_q.state = sepol_pkg::SEPOL_OFF; // RULE11
                    end else begin
                        nxt_q.state = sepol_pkg::SEPOL_ON; // RULE8
                    end
                end else begin
                    nxt_q.cnt = q_ff.cnt + `SEPOL_CNT_ONE;
                end
            end
            sepol_pkg::SEPOL_ON: begin
                if (!ok || !en_eff) begin // RULE1 RULE4
                    nxt_q.state = sepol_pkg::SEPOL_OFF;
                end
            end
            default: begin
                nxt_q.state = sepol_pkg::SEPOL_OFF;
            end
        endcase

        // Restart stands for control power restore: new settings apply
        // and the detection result is forgotten.
        if (restart) begin
            nxt_q.act = q_ff.cfg; // RULE2
            nxt_q.done = 1'b0; // RULE13
            nxt_q.state = sepol_pkg::SEPOL_OFF;
        end

        nxt_q.pwr = nxt_q.state != sepol_pkg::SEPOL_OFF;
        nxt_q.det = nxt_q.state == sepol_pkg::SEPOL_DETECT;
        nxt_q.rdy = ok && (!nxt_q.act.need_det || nxt_q.done); // RULE8 RULE11 RULE18
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Reset loads constants only; the config defaults to terminal enable.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_ff <= '0;
            q_ff.cfg <= sepol_pkg::sepol_cfg_s'(`SEPOL_CFG_RST);
            q_ff.act <= sepol_pkg::sepol_cfg_s'(`SEPOL_CFG_RST);
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    enable_drop_off_a: assert property ( // RULE1
        q_ff.state == sepol_pkg::SEPOL_ON && !en_eff |=> !motor_power)
        else $error("Power stayed on after enable dropped.");

    always_on_power_a: assert property ( // RULE5
        q_ff.state == sepol_pkg::SEPOL_OFF && q_ff.act.src == `SEPOL_SRC_ALWAYS
        && ok && !motor_moving && !need && !restart |=> motor_power)
        else $error("Always-on enable did not power the motor.");

    moving_refused_a: assert property ( // RULE3
        q_ff.state == sepol_pkg::SEPOL_OFF && motor_moving |=> !motor_power)
        else $error("Enable taken while the motor moved.");

    blocked_no_power_a: assert property ( // RULE4
        !ok |=> !motor_power && !detecting)
        else $error("Power on without main power or with block or alarm.");

    detect_once_a: assert property ( // RULE12
        q_ff.done |=> !detecting)
        else $error("Detection ran again after completion.");

    detect_finish_a: assert property ( // RULE10
        detecting && q_ff.cnt == DET_LAST && ok && (q_ff.act.alloc || en_eff)
        && !restart |=> q_ff.done)
        else $error("Detection did not complete at the end of its run.");

    alloc1_end_a: assert property ( // RULE11
        detecting && q_ff.act.alloc && q_ff.cnt == DET_LAST && ok && !restart
        |=> !motor_power && servo_ready)
        else $error("Allocation 1 detection end wrong.");

    alloc0_end_a: assert property ( // RULE8
        detecting && !q_ff.act.alloc && q_ff.cnt == DET_LAST && ok && en_eff
        && !restart |=> motor_power && servo_ready)
        else $error("Allocation 0 detection end wrong.");

    ready_blocked_a: assert property ( // RULE18
        !ok |=> !servo_ready)
        else $error("Ready high during alarm or safety block.");

    restart_clears_a: assert property ( // RULE13
        restart |=> !q_ff.done && !detecting && !motor_power)
        else $error("Restart kept the detection result.");

    // ------------------------------------------------------------
    // Entry, hold and restart checks
    // ------------------------------------------------------------

    // Settings move only at restart, so a bus write cannot upset a running sequence.
    config_hold_a: assert property ( // RULE2
        !restart |=> $stable(q_ff.act))
        else $error("Active settings changed without a restart.");

    alloc0_start_a: assert property ( // RULE7
        q_ff.state == sepol_pkg::SEPOL_OFF && ok && !motor_moving && need
        && !q_ff.act.alloc && en_eff && !restart |=> detecting && motor_power)
        else $error("Enable did not start detection in allocation 0.");

    // The request is read after its synchroniser, as the sequencer sees it.
    alloc1_start_a: assert property ( // RULE9
        q_ff.state == sepol_pkg::SEPOL_OFF && ok && !motor_moving && need
        && q_ff.act.alloc && q_ff.s2[0] && !restart |=> detecting && motor_power)
        else $error("Request did not power the motor in allocation 1.");

    request_always_a: assert property ( // RULE14
        q_ff.state == sepol_pkg::SEPOL_OFF && ok && !motor_moving && need
        && q_ff.act.alloc && q_ff.act.pol_always && !restart |=> detecting)
        else $error("Always-on request did not start detection.");

    needless_detect_a: assert property ( // RULE15
        detecting |-> q_ff.act.need_det && !q_ff.done)
        else $error("Detection ran while not required.");

    // Covers both the first power-up and the return after an alarm clears.
    enable_resume_a: assert property ( // RULE6
        q_ff.state == sepol_pkg::SEPOL_OFF && ok && !motor_moving && !need
        && en_eff && !restart |=> motor_power)
        else $error("Power did not return with enable in effect.");

    done_kept_a: assert property ( // RULE12
        q_ff.done && !restart |=> q_ff.done)
        else $error("Detection result lost without a restart.");

    restart_unready_a: assert property ( // RULE13
        restart && q_ff.cfg.need_det |=> !servo_ready)
        else $error("Ready stayed high after a restart that needs detection.");

    enable_kept_a: assert property ( // RULE8
        q_ff.state == sepol_pkg::SEPOL_ON && q_ff.done && ok && en_eff && !restart
        |=> motor_power && servo_ready)
        else $error("Ready or power lost while enable stayed in effect.");

    alloc1_idle_a: assert property ( // RULE11
        q_ff.state == sepol_pkg::SEPOL_OFF && q_ff.act.alloc && q_ff.done && !en_eff
        |=> !motor_power)
        else $error("Motor powered after detection without enable.");

    // ------------------------------------------------------------
    // Coverage of the main scenarios
    // ------------------------------------------------------------
    detect_done_c: cover property (detecting ##1 !detecting && servo_ready);
    alloc1_done_c: cover property (q_ff.act.alloc && q_ff.done && !motor_power);
    always_on_c: cover property (q_ff.act.src == `SEPOL_SRC_ALWAYS && motor_power);
    moving_wait_c: cover property (q_ff.state == sepol_pkg::SEPOL_OFF && motor_moving && en_eff);
    request_always_c: cover property (q_ff.act.pol_always && detecting);

endmodule

// File: verilog/sepol_defines.svh
`ifndef SEPOL_DEFINES_SVH
`define SEPOL_DEFINES_SVH

// ------------------------------------------------------------
// Register map (byte addresses) and bus answers
// ------------------------------------------------------------
`define SEPOL_ADDR_W 4
`define SEPOL_CFG_OFS 4'h0
`define SEPOL_CTRL_OFS 4'h4
`define SEPOL_STAT_OFS 4'h8
`define SEPOL_RESP_OKAY 2'h0
`define SEPOL_RESP_SLVERR 2'h2

// ------------------------------------------------------------
// Configuration field values and reset image
// ------------------------------------------------------------
`define SEPOL_SRC_TERMINAL 4'h0
`define SEPOL_SRC_ALWAYS 4'h7
`define SEPOL_CFG_W 7
`define SEPOL_CFG_RST 7'h40
`define SEPOL_CTRL_RESTART_BIT 0
`define SEPOL_STAT_PAD 27'h0
`define SEPOL_CFG_PAD 25'h0

// ------------------------------------------------------------
// Detection run time
// ------------------------------------------------------------
`define SEPOL_DET_TIME_US 1000
`define SEPOL_CLK_MHZ 25
`define SEPOL_DET_CYCLES (`SEPOL_DET_TIME_US * `SEPOL_CLK_MHZ)
`define SEPOL_CNT_W 20
`define SEPOL_CNT_ONE 20'h1

`endif

// File: verilog/sepol_pkg.sv
`include "sepol_defines.svh"

package sepol_pkg;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEPOL_OFF,
        SEPOL_DETECT,
        SEPOL_ON
    } sepol_state_e;

    // ------------------------------------------------------------
    // Configuration word, most significant field first
    // ------------------------------------------------------------
    typedef struct packed {
        logic need_det;
        logic pol_always;
        logic alloc;
        logic [3:0] src;
    } sepol_cfg_s;

    // ------------------------------------------------------------
    // Whole state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        sepol_cfg_s cfg;
        sepol_cfg_s act;
        sepol_state_e state;
        logic [`SEPOL_CNT_W-1:0] cnt;
        logic done;
        logic pwr;
        logic rdy;
        logic det;
        logic aw_got;
        logic w_got;
        logic wstrb0;
        logic [`SEPOL_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } sepol_st_s;

endpackage

// File: testbench/sepol_host.sv
// ------------------------------------------------------------
// Host controller model driving the discrete sequence inputs
// ------------------------------------------------------------
module sepol_host (
    input wire logic aclk, // System clock.
    input wire logic en_cmd, // Bench asks for servo enable.
    input wire logic det_cmd, // Bench asks for polarity detection.
    output logic servo_enable_in, // Enable terminal.
    output logic polarity_detect_req // Detection request terminal.
);
    timeunit 1ns;
    timeprecision 1ns;

    // Terminals start released so reset sees a quiet host.
    initial begin
        servo_enable_in = 1'b0;
        polarity_detect_req = 1'b0;
    end

    // A controller's outputs change just after an edge, never on it.
    // Enable is raised before any reference; detection has its own terminal.
    always @(posedge aclk) begin
        servo_enable_in <= en_cmd;
        polarity_detect_req <= det_cmd;
    end
endmodule

// File: testbench/testbench.sv
`include "sepol_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp;
    logic en, det, sen, preq, mp_ok, hsb, alarm, moving, mpwr, srdy, dtc;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [6:0] cfgs [3] = '{7'h47, 7'h70, 7'h07};
    logic [2:0] mids [3] = '{3'b101, 3'b101, 3'b011};
    logic [2:0] fins [3] = '{3'b011, 3'b010, 3'b011};

    sepol_host i_host (.aclk(aclk), .en_cmd(en), .det_cmd(det), .servo_enable_in(sen),
        .polarity_detect_req(preq));

    sepol_top #(.DET_CYCLES(8)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .servo_enable_in(sen), .polarity_detect_req(preq),
        .main_power_ok(mp_ok), .hardwired_safety_block(hsb), .alarm_active(alarm),
        .motor_moving(moving), .motor_power(mpwr), .servo_ready(srdy), .detecting(dtc));

    // ------------------------------------------------------------
    // Clock, verdict and comparison helpers
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task test_done();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits, bounded, for {detecting, ready, power} to reach a value.
    task wait_out(input logic [2:0] exp);
        for (int n = 0; n < 200 && {dtc, srdy, mpwr} !== exp; n++) @(posedge aclk);
        chk({29'h0, dtc, srdy, mpwr}, {29'h0, exp});
        // A wait that ran out is already counted; the run ends here.
        if ({dtc, srdy, mpwr} !== exp) begin
            test_done();
        end
    endtask

    // ------------------------------------------------------------
    // Register bus master; every wait is bounded
    // ------------------------------------------------------------
    task axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ad;
        bit dd;
        int n;
        ad = 0;
        dd = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50 && !(ad && dd); n++) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                dd = 1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        for (n = 0; n < 50 && bvalid !== 1'b1; n++) @(posedge aclk);
        if (bvalid !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask

    task axr(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50 && !(arvalid && arready); n++) @(posedge aclk);
        arvalid <= 1'b0;
        for (n = 0; n < 50 && rvalid !== 1'b1; n++) @(posedge aclk);
        if (rvalid !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
        d = rdata;
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        {en, det, mp_ok, hsb, alarm, moving} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`SEPOL_CFG_OFS, rd, `SEPOL_RESP_OKAY);
        chk(rd, 32'h00000040);
        axr(4'hC, rd, `SEPOL_RESP_SLVERR);
        axr(`SEPOL_CTRL_OFS, rd, `SEPOL_RESP_OKAY);
        chk(rd, 32'h00000000);
        axw(4'hC, 32'h00000001, `SEPOL_RESP_SLVERR);
        axw(`SEPOL_STAT_OFS, 32'h0000001F, `SEPOL_RESP_OKAY);
        // A write without lane 0 must leave the settings alone.
        wstrb <= 4'hE;
        axw(`SEPOL_CFG_OFS, 32'h00000007, `SEPOL_RESP_OKAY);
        wstrb <= 4'hF;
        axr(`SEPOL_CFG_OFS, rd, `SEPOL_RESP_OKAY);
        chk(rd, 32'h00000040);
        // Default allocation: enable starts detection, ready follows.
        mp_ok <= 1'b1;
        en <= 1'b1;
        wait_out(3'b101);
        wait_out(3'b011);
        axr(`SEPOL_STAT_OFS, rd, `SEPOL_RESP_OKAY);
        chk(rd, 32'h0000001B);
        alarm <= 1'b1;
        wait_out(3'b000);
        alarm <= 1'b0;
        wait_out(3'b011);
        hsb <= 1'b1;
        wait_out(3'b000);
        en <= 1'b0;
        hsb <= 1'b0;
        wait_out(3'b010);
        // An enable raised while moving must wait for standstill.
        moving <= 1'b1;
        en <= 1'b1;
        repeat (10) @(posedge aclk);
        chk({31'h0, mpwr}, 32'h0);
        moving <= 1'b0;
        wait_out(3'b011);
        en <= 1'b0;
        // Restart into the separate request allocation.
        axw(`SEPOL_CFG_OFS, 32'h00000050, `SEPOL_RESP_OKAY);
        axw(`SEPOL_CTRL_OFS, 32'h00000001, `SEPOL_RESP_OKAY);
        wait_out(3'b000);
        det <= 1'b1;
        wait_out(3'b101);
        det <= 1'b0;
        wait_out(3'b010);
        det <= 1'b1;
        repeat (8) @(posedge aclk);
        chk({30'h0, dtc, mpwr}, 32'h0);
        det <= 1'b0;
        // Always-on enable, always-on request, and no detection needed.
        for (int i = 0; i < 3; i++) begin
            mp_ok <= 1'b0;
            axw(`SEPOL_CFG_OFS, {25'h0, cfgs[i]}, `SEPOL_RESP_OKAY);
            axw(`SEPOL_CTRL_OFS, 32'h00000001, `SEPOL_RESP_OKAY);
            wait_out(3'b000);
            mp_ok <= 1'b1;
            wait_out(mids[i]);
            wait_out(fins[i]);
        end
        test_done();
    end
endmodule
